// File: tx_pause_flow_control_regs.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module tx_pause_flow_control_regs #(
    // Arbitrary neutral identification values
    parameter logic [31:0] REVISION_ID = 32'h0000_0001,
    parameter logic [31:0] IDENT_WORD0 = 32'h7478_666c,
    parameter logic [31:0] IDENT_WORD1 = 32'h6f77_6374,
    parameter logic [31:0] IDENT_WORD2 = 32'h6c72_6567
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [flowctl_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [flowctl_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [flowctl_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [flowctl_pkg::NUM_QUEUES-1:0] pause_insert_in,
    input wire flowctl_pkg::tx_beat_type client_in,
    output logic client_ready_out,
    output flowctl_pkg::tx_beat_type link_out
);

    localparam int NQ = flowctl_pkg::NUM_QUEUES;
    localparam int QW = flowctl_pkg::QUANTA_W;

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [31:0] scratch; // Free test word
    logic [31:0] next_scratch;
    logic [NQ-1:0] pause_enable; // Per-queue pause enable
    logic [NQ-1:0] next_pause_enable;
    logic [NQ-1:0] pause_request; // Software pause request levels
    logic [NQ-1:0] next_pause_request;
    logic [NQ-1:0] holdoff_enable; // Per-queue XOFF retransmit enable
    logic [NQ-1:0] next_holdoff_enable;
    logic [flowctl_pkg::QSEL_W-1:0] queue_select; // Window entry pointer
    logic [flowctl_pkg::QSEL_W-1:0] next_queue_select;
    logic [QW-1:0] holdoff_table [NQ]; // Retransmit interval per queue
    logic [QW-1:0] next_holdoff_table [NQ];
    logic [QW-1:0] quanta_table [NQ]; // Pause time per queue
    logic [QW-1:0] next_quanta_table [NQ];
    logic [31:0] next_rdata;

    // Decode writes and build the read word for the next cycle
    always_comb begin
        next_scratch = scratch;
        next_pause_enable = pause_enable;
        next_pause_request = pause_request;
        next_holdoff_enable = holdoff_enable;
        next_queue_select = queue_select;
        next_holdoff_table = holdoff_table;
        next_quanta_table = quanta_table;
        next_rdata = 32'h0000_0000;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                flowctl_pkg::OFF_SCRATCH: next_scratch = reg_wdata_in;
                flowctl_pkg::OFF_PAUSE_EN: next_pause_enable = reg_wdata_in[NQ-1:0];
                flowctl_pkg::OFF_PAUSE_REQ: next_pause_request = reg_wdata_in[NQ-1:0];
                flowctl_pkg::OFF_HOLDOFF_EN: next_holdoff_enable = reg_wdata_in[NQ-1:0];
                flowctl_pkg::OFF_QUEUE_SELECT: begin
                    // Last value written chooses the table entry
                    next_queue_select = reg_wdata_in[flowctl_pkg::QSEL_W-1:0];
                end
                flowctl_pkg::OFF_HOLDOFF_WIN: begin
                    next_holdoff_table[queue_select] = reg_wdata_in[QW-1:0];
                end
                flowctl_pkg::OFF_QUANTA_WIN: begin
                    next_quanta_table[queue_select] = reg_wdata_in[QW-1:0];
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
        if (reg_read_in) begin
            unique case (reg_addr_in)
                flowctl_pkg::OFF_REVISION: next_rdata = REVISION_ID;
                flowctl_pkg::OFF_SCRATCH: next_rdata = scratch;
                flowctl_pkg::OFF_IDENT0: next_rdata = IDENT_WORD0;
                flowctl_pkg::OFF_IDENT1: next_rdata = IDENT_WORD1;
                flowctl_pkg::OFF_IDENT2: next_rdata = IDENT_WORD2;
                flowctl_pkg::OFF_PAUSE_EN: next_rdata[NQ-1:0] = pause_enable;
                flowctl_pkg::OFF_PAUSE_REQ: next_rdata[NQ-1:0] = pause_request;
                flowctl_pkg::OFF_HOLDOFF_EN: next_rdata[NQ-1:0] = holdoff_enable;
                flowctl_pkg::OFF_QUEUE_SELECT: begin
                    next_rdata[flowctl_pkg::QSEL_W-1:0] = queue_select;
                end
                flowctl_pkg::OFF_HOLDOFF_WIN: next_rdata[QW-1:0] = holdoff_table[queue_select];
                flowctl_pkg::OFF_QUANTA_WIN: next_rdata[QW-1:0] = quanta_table[queue_select];
                default: next_rdata = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Register the file and the read word
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            scratch <= flowctl_pkg::SCRATCH_RESET;
            pause_enable <= flowctl_pkg::PAUSE_EN_RESET;
            pause_request <= flowctl_pkg::PAUSE_REQ_RESET;
            holdoff_enable <= flowctl_pkg::HOLDOFF_EN_RESET;
            queue_select <= flowctl_pkg::QSEL_RESET;
            for (int i = 0; i < NQ; i++) begin
                holdoff_table[i] <= flowctl_pkg::HOLDOFF_RESET;
                quanta_table[i] <= flowctl_pkg::QUANTA_RESET;
            end
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            scratch <= next_scratch;
            pause_enable <= next_pause_enable;
            pause_request <= next_pause_request;
            holdoff_enable <= next_holdoff_enable;
            queue_select <= next_queue_select;
            holdoff_table <= next_holdoff_table;
            quanta_table <= next_quanta_table;
            reg_rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pause engine: request edges, pending frames, hold-off timers

    logic [NQ-1:0] request_level; // Insert input or register, per queue
    logic [NQ-1:0] request_prev; // Level one cycle ago
    logic [NQ-1:0] next_request_prev;
    logic [NQ-1:0] xoff_pend; // XOFF frame waiting for a gap
    logic [NQ-1:0] next_xoff_pend;
    logic [NQ-1:0] xon_pend; // XON frame waiting for a gap
    logic [NQ-1:0] next_xon_pend;
    logic [QW-1:0] holdoff_count [NQ]; // Quanta left before resend
    logic [QW-1:0] next_holdoff_count [NQ];
    logic [flowctl_pkg::TICK_W-1:0] tick_count; // Quantum prescaler
    logic [flowctl_pkg::TICK_W-1:0] next_tick_count;
    logic quantum_tick;
    logic [NQ-1:0] sent_xoff; // From the arbiter: frame sent this cycle
    logic [NQ-1:0] sent_xon;

    // Either request path counts; the two are ORed, neither one is preferred
    assign request_level = pause_request | pause_insert_in;
    assign quantum_tick = (tick_count == flowctl_pkg::TICK_W'(flowctl_pkg::QUANTUM_CYCLES - 1));

    // Compute pending frames and timer values
    always_comb begin
        next_request_prev = request_level;
        next_tick_count = quantum_tick ? '0 : tick_count + 1'b1;
        next_xoff_pend = xoff_pend & ~sent_xoff;
        next_xon_pend = xon_pend & ~sent_xon;
        next_holdoff_count = holdoff_count;
        for (int i = 0; i < NQ; i++) begin
            if (!request_level[i] || !holdoff_enable[i]) begin
                // Timer clears to zero once the request or hold-off is gone
                next_holdoff_count[i] = '0;
            end else if (sent_xoff[i]) begin
                next_holdoff_count[i] = holdoff_table[i];
            end else if (quantum_tick && holdoff_count[i] != '0) begin
                next_holdoff_count[i] = holdoff_count[i] - 1'b1;
                if (holdoff_count[i] == QW'(1)) begin
                    next_xoff_pend[i] = 1'b1;
                end
            end
            if (request_level[i] && !request_prev[i]) begin
                // Rising request: XOFF replaces any waiting XON
                next_xoff_pend[i] = 1'b1;
                next_xon_pend[i] = 1'b0;
            end else if (!request_level[i] && request_prev[i]) begin
                next_xon_pend[i] = 1'b1;
                next_xoff_pend[i] = 1'b0;
            end
            if (!pause_enable[i]) begin
                // Disabled queue never emits
                next_xoff_pend[i] = 1'b0;
                next_xon_pend[i] = 1'b0;
            end
        end
    end

    // Register the pause engine
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            request_prev <= '0;
            tick_count <= '0;
            xoff_pend <= '0;
            xon_pend <= '0;
            for (int i = 0; i < NQ; i++) begin
                holdoff_count[i] <= '0;
            end
        end else begin
            request_prev <= next_request_prev;
            tick_count <= next_tick_count;
            xoff_pend <= next_xoff_pend;
            xon_pend <= next_xon_pend;
            holdoff_count <= next_holdoff_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit arbiter: client frames and inserted pause frames

    flowctl_pkg::arb_state_type state; // Where the stream stands
    flowctl_pkg::arb_state_type next_state;
    flowctl_pkg::tx_beat_type next_link;
    logic next_client_ready;
    logic client_take; // Client beat accepted this cycle
    logic pick_valid; // Some pause frame is waiting
    logic pick_xon; // Chosen frame is XON
    logic [flowctl_pkg::QSEL_W-1:0] pick_queue; // Chosen queue, lowest first
    logic [flowctl_pkg::QSEL_W-1:0] send_queue; // Queue latched for insertion
    logic [flowctl_pkg::QSEL_W-1:0] next_send_queue;
    logic send_xon;
    logic next_send_xon;

    assign client_take = client_in.valid && client_ready_out;

    // Choose the next pause frame: XOFF over XON, low queue first
    always_comb begin
        pick_valid = 1'b0;
        pick_xon = 1'b0;
        pick_queue = '0;
        for (int i = NQ - 1; i >= 0; i--) begin
            if (xon_pend[i]) begin
                pick_valid = 1'b1;
                pick_xon = 1'b1;
                pick_queue = flowctl_pkg::QSEL_W'(i);
            end
        end
        for (int i = NQ - 1; i >= 0; i--) begin
            if (xoff_pend[i]) begin
                pick_valid = 1'b1;
                pick_xon = 1'b0;
                pick_queue = flowctl_pkg::QSEL_W'(i);
            end
        end
    end

    // Sequence the stream and build the outgoing beat
    always_comb begin
        next_state = state;
        next_send_queue = send_queue;
        next_send_xon = send_xon;
        next_link = '0;
        sent_xoff = '0;
        sent_xon = '0;
        unique case (state)
            flowctl_pkg::ST_IDLE, flowctl_pkg::ST_CLIENT: begin
                if (client_take) begin
                    // Pass the client beat straight on
                    next_link = client_in;
                    next_link.pause = 1'b0;
                end
                if (client_take && client_in.sop && !client_in.eop) begin
                    next_state = flowctl_pkg::ST_CLIENT;
                end else if (state == flowctl_pkg::ST_CLIENT && !(client_take && client_in.eop)) begin
                    // Never split a frame in flight
                    next_state = flowctl_pkg::ST_CLIENT;
                end else if (pick_valid) begin
                    // Gap between frames: claim it for a pause frame
                    next_state = flowctl_pkg::ST_PAUSE;
                    next_send_queue = pick_queue;
                    next_send_xon = pick_xon;
                end else begin
                    next_state = flowctl_pkg::ST_IDLE;
                end
            end
            flowctl_pkg::ST_PAUSE: begin
                // One descriptor beat; the framer expands it to a pause frame
                next_link.valid = 1'b1;
                next_link.sop = 1'b1;
                next_link.eop = 1'b1;
                next_link.pause = 1'b1;
                next_link.data[19] = send_xon;
                next_link.data[18:16] = send_queue;
                next_link.data[15:0] = send_xon ? '0 : quanta_table[send_queue];
                sent_xoff[send_queue] = !send_xon;
                sent_xon[send_queue] = send_xon;
                next_state = flowctl_pkg::ST_IDLE; // Client traffic resumes
            end
            default: next_state = flowctl_pkg::ST_IDLE;
        endcase
        next_client_ready = (next_state != flowctl_pkg::ST_PAUSE);
    end

    // Register the arbiter and the stream outputs
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state <= flowctl_pkg::ST_IDLE;
            send_queue <= '0;
            send_xon <= 1'b0;
            link_out <= '0;
            client_ready_out <= 1'b0;
        end else begin
            state <= next_state;
            send_queue <= next_send_queue;
            send_xon <= next_send_xon;
            link_out <= next_link;
            client_ready_out <= next_client_ready;
        end
    end

endmodule

// File: flowctl_pkg.sv
package flowctl_pkg;

    // Register port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Priority queues: eight for priority-based control, each with its own enable, request and timers
    localparam int NUM_QUEUES = 8;
    localparam int QSEL_W = 3;
    localparam int QUANTA_W = 16;

    // Register offsets, one word each
    localparam logic [15:0] OFF_REVISION = 16'h0600;
    localparam logic [15:0] OFF_SCRATCH = 16'h0601;
    localparam logic [15:0] OFF_IDENT0 = 16'h0602;
    localparam logic [15:0] OFF_IDENT1 = 16'h0603;
    localparam logic [15:0] OFF_IDENT2 = 16'h0604;
    localparam logic [15:0] OFF_PAUSE_EN = 16'h0605;
    localparam logic [15:0] OFF_PAUSE_REQ = 16'h0606;
    localparam logic [15:0] OFF_HOLDOFF_EN = 16'h0607;
    localparam logic [15:0] OFF_HOLDOFF_WIN = 16'h0608;
    localparam logic [15:0] OFF_QUANTA_WIN = 16'h0609;
    localparam logic [15:0] OFF_QUEUE_SELECT = 16'h060a;

    // Values after reset
    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
    localparam logic [NUM_QUEUES-1:0] PAUSE_EN_RESET = 8'hff;
    localparam logic [NUM_QUEUES-1:0] PAUSE_REQ_RESET = 8'h00;
    localparam logic [NUM_QUEUES-1:0] HOLDOFF_EN_RESET = 8'hff;
    localparam logic [QUANTA_W-1:0] HOLDOFF_RESET = 16'hffff;
    localparam logic [QUANTA_W-1:0] QUANTA_RESET = 16'hffff;
    localparam logic [QSEL_W-1:0] QSEL_RESET = 3'h0;

    // One pause quantum is 512 bit times on a 40 Gb/s link
    localparam int QUANTUM_PS = 12800;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int QUANTUM_CYCLES = (QUANTUM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TICK_W = 4;

    // One beat of the transmit stream, client or inserted pause frame
    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic pause;
        logic [63:0] data;
    } tx_beat_type;

    // Arbiter states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CLIENT = 3'b010,
        ST_PAUSE = 3'b100
    } arb_state_type;

endpackage

// File: client_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Client frame source: sends a frame of len beats, each held until taken
module client_src (
    input wire logic ref_clk_in,
    input wire logic start_in,
    input wire logic [3:0] len_in,
    input wire logic ready_in,
    output flowctl_pkg::tx_beat_type beat_out,
    output logic busy_out
);
    logic [3:0] left = 4'h0; // Beats still to hand over
    logic [63:0] noise = 64'h0; // Idle data keeps moving so stale beats show
    ////////////////////////////////////////////////////////////////////////////
    // Count beats down as the block takes them
    always_ff @(posedge ref_clk_in) begin
        noise <= {noise[62:0], ~noise[63]};
        if (start_in) begin
            left <= len_in;
        end else if (busy_out && ready_in) begin
            left <= left - 4'h1;
        end
    end
    assign busy_out = (left != 4'h0);
    // Beat fields follow the count; no pause flag from the client
    always_comb begin
        beat_out.valid = busy_out;
        beat_out.sop = busy_out && (left == len_in);
        beat_out.eop = (left == 4'h1);
        beat_out.pause = 1'b0;
        beat_out.data = busy_out ? {60'h0, left} : noise;
    end
endmodule

// File: flowctl_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port-level checks for the pause register block
module flowctl_asserts #(
    parameter logic [31:0] REVISION_ID = 32'h0,
    parameter logic [31:0] IDENT_WORD0 = 32'h0
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [flowctl_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [flowctl_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [flowctl_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [flowctl_pkg::NUM_QUEUES-1:0] pause_insert_in,
    input wire flowctl_pkg::tx_beat_type client_in,
    input wire logic client_ready_out,
    input wire flowctl_pkg::tx_beat_type link_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic in_frame; // Link is inside a client frame
    logic next_in_frame;
    ////////////////////////////////////////////////////////////////////////////
    // Track client frames on the link
    always_comb begin
        next_in_frame = in_frame;
        if (link_out.valid && !link_out.pause) begin
            next_in_frame = !link_out.eop;
        end
        if (!reset_n_in) begin
            next_in_frame = 1'b0;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        in_frame <= next_in_frame;
    end
    ////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside answer cycle");
    revision_read_a: assert property (reg_read_in && reg_addr_in == 16'h0600
        |=> reg_rdata_out == REVISION_ID) else $error("revision word wrong");
    ident_read_a: assert property (reg_read_in && reg_addr_in == 16'h0602
        |=> reg_rdata_out == IDENT_WORD0) else $error("first ident word wrong");
    pause_shape_a: assert property (link_out.valid && link_out.pause
        |-> link_out.sop && link_out.eop && link_out.data[63:20] == 44'h0)
        else $error("pause beat malformed");
    xon_quanta_a: assert property (link_out.valid && link_out.pause && link_out.data[19]
        |-> link_out.data[15:0] == 16'h0) else $error("resume beat carries time");
    client_pass_a: assert property (client_in.valid && client_ready_out
        |=> link_out.valid && !link_out.pause && link_out.data == $past(client_in.data)
        && link_out.eop == $past(client_in.eop)) else $error("client beat not forwarded");
    pause_gap_a: assert property (in_frame |-> !link_out.pause)
        else $error("pause beat inside client frame");
    pause_stall_a: assert property (link_out.valid && link_out.pause
        |-> !$past(client_ready_out)) else $error("client not held off before pause beat");
    xoff_after_insert_a: assert property ($rose(pause_insert_in[0])
        |-> ##[1:40] (link_out.pause && link_out.data[19:16] == 4'h0))
        else $error("no stop beat after insert rise");
    xon_after_release_a: assert property ($fell(pause_insert_in[0])
        |-> ##[1:40] (link_out.pause && link_out.data[19:16] == 4'h8))
        else $error("no resume beat after insert fall");
    // Main scenarios reached
    xoff_seen_c: cover property (link_out.pause && !link_out.data[19]);
    xon_seen_c: cover property (link_out.pause && link_out.data[19]);
    frame_end_c: cover property (link_out.valid && link_out.eop && !link_out.pause);
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Register, pause and client traffic checks
module tb_top;
    // Arbitrary neutral identification values
    localparam logic [31:0] REV = 32'h0000_00a1;
    localparam logic [31:0] ID0 = 32'h6162_6364;
    localparam logic [31:0] ID1 = 32'h6566_6768;
    localparam logic [31:0] ID2 = 32'h696a_6b6c;
    logic ref_clk_in = 1'b0; // 200 MHz clock
    logic reset_n_in = 1'b0; // Synchronous reset
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] insert = 8'h0; // Client pause request levels
    logic start = 1'b0; // Starts a client frame
    flowctl_pkg::tx_beat_type client;
    flowctl_pkg::tx_beat_type link;
    logic ready;
    logic busy;
    int n_errors = 0;
    int tests_run = 0;
    int n_beats = 0; // Client beats seen on the link
    always #2.5 ref_clk_in = ~ref_clk_in;
    tx_pause_flow_control_regs #(.REVISION_ID(REV), .IDENT_WORD0(ID0), .IDENT_WORD1(ID1),
        .IDENT_WORD2(ID2)) tx_pause_flow_control_regs_i (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .pause_insert_in(insert), .client_in(client), .client_ready_out(ready),
        .link_out(link));
    client_src client_src_i (.ref_clk_in(ref_clk_in), .start_in(start), .len_in(4'h6),
        .ready_in(ready), .beat_out(client), .busy_out(busy));
    // Count forwarded client beats
    always_ff @(posedge ref_clk_in) begin
        if (link.valid && !link.pause) begin
            n_beats <= n_beats + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp, what);
    endtask
    // Waits for a pause beat of one queue and kind, then checks its time
    task automatic wait_pause(input logic [2:0] q, input logic xon, input logic [15:0] t);
        logic found;
        found = 1'b0;
        for (int i = 0; i < 200 && !found; i++) begin
            @(posedge ref_clk_in);
            #1 found = link.valid && link.pause && link.data[19:16] == {xon, q};
        end
        chk({31'h0, found}, 32'h1, "pause beat");
        chk({16'h0, link.data[15:0]}, {16'h0, t}, "pause time");
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ident();
        rd_chk(16'h0600, REV, "revision");
        rd_chk(16'h0602, ID0, "ident0");
        rd_chk(16'h0603, ID1, "ident1");
        rd_chk(16'h0604, ID2, "ident2");
        rd_chk(16'h0601, 32'h0, "scratch reset");
        wr_reg(16'h0601, 32'ha5c3_0ff1);
        rd_chk(16'h0601, 32'ha5c3_0ff1, "scratch");
        wr_reg(16'h0600, 32'hffff_ffff);
        rd_chk(16'h0600, REV, "revision kept");
        rd_chk(16'h06ff, 32'h0, "unmapped");
    endtask
    task automatic t_fields();
        rd_chk(16'h0605, 32'hff, "enable reset");
        wr_reg(16'h0605, 32'hffff_ff7f);
        rd_chk(16'h0605, 32'h7f, "enable width");
        wr_reg(16'h0605, 32'hff);
        rd_chk(16'h0606, 32'h0, "request reset");
        rd_chk(16'h0607, 32'hff, "holdoff enable");
        wr_reg(16'h0607, 32'h0000_010f);
        rd_chk(16'h0607, 32'h0f, "holdoff enable width");
        wr_reg(16'h0607, 32'hff);
    endtask
    // Each queue gets its own time; hold-off of two quanta everywhere
    task automatic t_window();
        for (int q = 0; q < 8; q++) begin
            wr_reg(16'h060a, 32'(q));
            rd_chk(16'h0609, 32'hffff, "quanta reset");
            wr_reg(16'h0609, 32'h0100 + 32'(q));
            wr_reg(16'h0608, 32'h2);
        end
        for (int q = 0; q < 8; q++) begin
            wr_reg(16'h060a, 32'(q));
            rd_chk(16'h0609, 32'h0100 + 32'(q), "quanta");
            rd_chk(16'h0608, 32'h2, "holdoff");
        end
        rd_chk(16'h060a, 32'h7, "queue select");
    endtask
    task automatic t_reg_pause();
        wr_reg(16'h0606, 32'h08);
        wait_pause(3'h3, 1'b0, 16'h0103);
        wait_pause(3'h3, 1'b0, 16'h0103);
        wr_reg(16'h0606, 32'h0);
        wait_pause(3'h3, 1'b1, 16'h0);
    endtask
    task automatic t_disabled();
        int seen;
        seen = 0;
        wr_reg(16'h0605, 32'hdf);
        insert[5] <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk_in);
            if (i == 30) insert[5] <= 1'b0;
            #1 if (link.valid && link.pause && link.data[18:16] == 3'h5) seen++;
        end
        chk(seen, 0, "disabled queue");
        wr_reg(16'h0605, 32'hff);
    endtask
    // Pause asked for while a client frame is under way
    task automatic t_mid_frame();
        int base;
        base = n_beats;
        @(posedge ref_clk_in);
        start <= 1'b1;
        @(posedge ref_clk_in);
        start <= 1'b0;
        insert[0] <= 1'b1;
        wait_pause(3'h0, 1'b0, 16'h0100);
        for (int i = 0; i < 50 && busy; i++) @(posedge ref_clk_in);
        repeat (2) @(posedge ref_clk_in);
        #1 chk(n_beats - base, 6, "client beats");
        @(posedge ref_clk_in);
        insert[0] <= 1'b0;
        wait_pause(3'h0, 1'b1, 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        t_ident();
        t_fields();
        t_window();
        t_reg_pause();
        t_disabled();
        t_mid_frame();
        repeat (5) @(posedge ref_clk_in);
        report_and_stop();
    end
    // Watchdog well past the expected run of a few hundred cycles
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
endmodule
bind tx_pause_flow_control_regs flowctl_asserts #(.REVISION_ID(REVISION_ID),
    .IDENT_WORD0(IDENT_WORD0)) flowctl_asserts_i (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .pause_insert_in(pause_insert_in), .client_in(client_in),
    .client_ready_out(client_ready_out), .link_out(link_out));
